// [design/pmc_regs.svh]
// Register offsets, field positions, reset values and timing counts for the power-mode controller
// Function
// - Deep stop gates system clock, turns oscillator off, halts execution.
// - Core-halt stops core only; system clock keeps running for peripherals.
// - Modes entered only by power-save instruction; operand selects which.
// - Wake on enabled interrupt, any reset, or watchdog time-out.
// - Deep stop disables system-clocked peripherals; external-clock ones continue (code drives every periph_en bit low in deep stop).
// - Low-power RC stays on in deep stop when watchdog enabled.
// - Watchdog counter cleared on entry into deep stop and core-halt.
// - Clock failure monitor inactive throughout deep stop.
// - Wake from deep stop resumes on clock source selected at entry.
// - Low-power RC on in core-halt if watchdog or monitor enabled.
// - Core-halt wake restarts execution 2 to 4 cycles after clock returns.
// - Interrupt during power-save instruction deferred, then wakes immediately.
// - Slowdown reduces core clock only; peripherals keep register access.
// - Slowdown enable is clock divider register bit 11.
// - Ratio field bits 14:12 selects eight ratios, default 1:1.
// - Restore-on-interrupt bit 15 returns core to full speed on interrupt.
// - Unlocked configuration lets software write new-oscillator select bits 10:8.
// - Core-halt keeps peripherals running by default, individually disableable.
// - Slowdown leaves peripheral clocking, hence bit rates, unchanged.
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
`define PMC_ADDR_OSC_CTRL 4'h0
`define PMC_ADDR_CLK_DIV 4'h1
`define PMC_ADDR_STATUS 4'h2
`define PMC_ADDR_PERIPH_DIS 4'h3
`define PMC_NEW_OSC_SELECT_HI 10
`define PMC_NEW_OSC_SELECT_LO 8
`define PMC_SLOWDOWN_ENABLE_BIT 11
`define PMC_RATIO_HI 14
`define PMC_RATIO_LO 12
`define PMC_ROI_BIT 15
`define PMC_OSC_RST 3'h0
`define PMC_CLOCK_DIVIDER_REG_RST 16'h0000
`define PMC_WAKE_DLY_MIN 2
`define PMC_WAKE_DLY_CYC 3'h2
`endif

// [design/pmc_pkg.sv]
// Types shared by the power-mode controller
package pmc_pkg;
    typedef enum logic [3:0] {
        PMC_RUN = 4'h1,
        PMC_STOP = 4'h2,
        PMC_HALT = 4'h4,
        PMC_WAKE = 4'h8
    } pmc_state_e;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pmc_bus_s;
    typedef struct packed {
        logic sys_clk_en;
        logic osc_en;
        logic low_power_rc_osc_en;
        logic core_clk_en;
        logic periph_clk_en;
        logic clock_failure_monitor_active;
        logic wdt_clear;
    } pmc_ctrl_s;
endpackage

// [design/pmc_top.sv]
// Power-mode controller: deep stop, core-halt, slowdown and oscillator request
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "pmc_regs.svh"
module pmc_top #(
    parameter int NPERIPH = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire pmc_pkg::pmc_bus_s bus,
    output logic [15:0] rdata,
    // Core side
    input wire logic power_save_instruction_exec,
    input wire logic power_save_instruction_stop,
    input wire logic irq_pending,
    input wire logic cfg_locked,
    // Watchdog and monitor
    input wire logic wdt_enabled,
    input wire logic wdt_timeout,
    input wire logic clock_failure_monitor_enabled,
    input wire logic [2:0] cur_osc,
    // Clock controls
    output pmc_pkg::pmc_ctrl_s ctrl,
    output logic core_tick,
    output logic [2:0] resume_osc,
    output logic [2:0] new_osc_select,
    output logic [NPERIPH-1:0] periph_en,
    output logic exec_restart
);
    import pmc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    pmc_state_e state_q, state_d;
    logic [2:0] wait_q, wait_d;
    logic [2:0] osc_q, osc_d;
    logic [2:0] resume_q, resume_d;
    logic [15:0] clock_divider_reg_q, clock_divider_reg_d;
    logic [NPERIPH-1:0] pdis_q, pdis_d;
    logic [6:0] div_cnt_q, div_cnt_d;
    logic slow_q, slow_d;
    logic [15:0] rdata_q, rdata_d;
    pmc_ctrl_s ctrl_q, ctrl_d;
    logic tick_q, tick_d;
    logic [NPERIPH-1:0] pen_q, pen_d;
    logic restart_q, restart_d;
    logic irq_hold_q, irq_hold_d;
    logic wdt_clear_d;
    logic wake;

    // Ratio code to divide mask
    function automatic logic [6:0] ratio_mask(input logic [2:0] code);
        ratio_mask = 7'((8'h01 << code) - 8'h01);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // wake sources; reset wakes by restarting state
    assign wake = irq_pending | wdt_timeout | irq_hold_q;

    always_comb begin
        state_d = state_q;
        wait_d = wait_q;
        resume_d = resume_q;
        irq_hold_d = 1'b0;
        restart_d = 1'b0;
        wdt_clear_d = 1'b0;
        case (state_q)
            PMC_RUN: begin
                if (power_save_instruction_exec) begin
                    wdt_clear_d = wdt_enabled;
                    irq_hold_d = irq_pending;
                    if (power_save_instruction_stop) begin
                        resume_d = cur_osc;
                        state_d = PMC_STOP;
                    end else begin
                        state_d = PMC_HALT;
                    end
                end
            end
            PMC_STOP: begin
                if (wake) begin
                    state_d = PMC_WAKE;
                    wait_d = `PMC_WAKE_DLY_CYC;
                end
            end
            PMC_HALT: begin
                if (wake) begin
                    state_d = PMC_WAKE;
                    wait_d = `PMC_WAKE_DLY_CYC;
                end
            end
            PMC_WAKE: begin
                if (wait_q <= 3'h1) begin
                    state_d = PMC_RUN;
                    restart_d = 1'b1;
                end else begin
                    wait_d = wait_q - 3'h1;
                end
            end
            default: begin
                state_d = PMC_RUN;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        ctrl_d.sys_clk_en = 1'b1;
        ctrl_d.osc_en = 1'b1;
        ctrl_d.core_clk_en = 1'b0;
        ctrl_d.periph_clk_en = 1'b1;
        ctrl_d.clock_failure_monitor_active = clock_failure_monitor_enabled;
        ctrl_d.low_power_rc_osc_en = 1'b1;
        // One process owns the whole control word
        ctrl_d.wdt_clear = wdt_clear_d;
        pen_d = ~pdis_q;
        case (state_d)
            PMC_STOP: begin
                ctrl_d.sys_clk_en = 1'b0;
                ctrl_d.osc_en = 1'b0;
                ctrl_d.periph_clk_en = 1'b0;
                pen_d = '0;
                ctrl_d.clock_failure_monitor_active = 1'b0;
                ctrl_d.low_power_rc_osc_en = wdt_enabled;
            end
            PMC_HALT: begin
                // RC kept for watchdog or monitor
                ctrl_d.low_power_rc_osc_en = wdt_enabled | clock_failure_monitor_enabled;
            end
            PMC_WAKE: begin
                ctrl_d.core_clk_en = 1'b1;
            end
            default: begin
                ctrl_d.core_clk_en = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        osc_d = osc_q;
        clock_divider_reg_d = clock_divider_reg_q;
        pdis_d = pdis_q;
        rdata_d = 16'h0000;
        if (bus.wr) begin
            case (bus.addr)
                `PMC_ADDR_OSC_CTRL: begin
                    if (!cfg_locked) begin
                        osc_d = bus.wdata[`PMC_NEW_OSC_SELECT_HI:`PMC_NEW_OSC_SELECT_LO];
                    end
                end
                `PMC_ADDR_CLK_DIV: begin
                    clock_divider_reg_d = 16'h0000;
                    clock_divider_reg_d[`PMC_ROI_BIT:`PMC_SLOWDOWN_ENABLE_BIT] = bus.wdata[`PMC_ROI_BIT:`PMC_SLOWDOWN_ENABLE_BIT];
                end
                `PMC_ADDR_PERIPH_DIS: begin
                    pdis_d = bus.wdata[NPERIPH-1:0];
                end
                default: begin
                end
            endcase
        end
        if (clock_divider_reg_q[`PMC_ROI_BIT] && irq_pending) begin
            clock_divider_reg_d[`PMC_SLOWDOWN_ENABLE_BIT] = 1'b0;
        end
        if (bus.rd) begin
            case (bus.addr)
                `PMC_ADDR_OSC_CTRL: rdata_d[`PMC_NEW_OSC_SELECT_HI:`PMC_NEW_OSC_SELECT_LO] = osc_q;
                `PMC_ADDR_CLK_DIV: rdata_d = clock_divider_reg_q;
                `PMC_ADDR_STATUS: rdata_d = {9'h000, slow_q, resume_q, state_q[3:1]};
                `PMC_ADDR_PERIPH_DIS: rdata_d[NPERIPH-1:0] = pdis_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core tick divides, peripheral clock untouched
    always_comb begin
        slow_d = clock_divider_reg_q[`PMC_SLOWDOWN_ENABLE_BIT];
        div_cnt_d = div_cnt_q;
        tick_d = 1'b0;
        if (state_d == PMC_RUN) begin
            if (!slow_q || div_cnt_q >= ratio_mask(clock_divider_reg_q[`PMC_RATIO_HI:`PMC_RATIO_LO])) begin
                div_cnt_d = 7'h00;
                tick_d = 1'b1;
            end else begin
                div_cnt_d = div_cnt_q + 7'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= PMC_RUN;
            wait_q <= 3'h0;
            resume_q <= `PMC_OSC_RST;
            osc_q <= `PMC_OSC_RST;
            clock_divider_reg_q <= `PMC_CLOCK_DIVIDER_REG_RST;
            pdis_q <= '0;
            div_cnt_q <= 7'h00;
            slow_q <= 1'b0;
            rdata_q <= 16'h0000;
            ctrl_q <= '0;
            tick_q <= 1'b0;
            pen_q <= '0;
            restart_q <= 1'b0;
            irq_hold_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wait_q <= wait_d;
            resume_q <= resume_d;
            osc_q <= osc_d;
            clock_divider_reg_q <= clock_divider_reg_d;
            pdis_q <= pdis_d;
            div_cnt_q <= div_cnt_d;
            slow_q <= slow_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
            tick_q <= tick_d;
            pen_q <= pen_d;
            restart_q <= restart_d;
            irq_hold_q <= irq_hold_d;
        end
    end

    assign rdata = rdata_q;
    assign ctrl = ctrl_q;
    assign core_tick = tick_q;
    assign resume_osc = resume_q;
    assign new_osc_select = osc_q;
    assign periph_en = pen_q;
    assign exec_restart = restart_q;
endmodule // pmc_top

// [verification/pmc_core_mdl.sv]
// Core model: one instruction slot per core tick, counts restarts
`timescale 1ns/10ps
module pmc_core_mdl (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Core enables
    input wire logic core_tick,
    input wire logic exec_restart,
    // Counts
    output logic [15:0] ticks,
    output logic [7:0] restarts
);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ticks <= 16'h0000;
            restarts <= 8'h00;
        end else begin
            ticks <= ticks + {15'h0000, core_tick};
            restarts <= restarts + {7'h00, exec_restart};
        end
    end
endmodule // pmc_core_mdl

// [verification/pmc_chk.sv]
// Port checker for the power-mode controller
`timescale 1ns/10ps
`include "pmc_regs.svh"
module pmc_chk #(
    parameter int NPERIPH = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Inputs
    input wire pmc_pkg::pmc_bus_s bus,
    input wire logic power_save_instruction_exec,
    input wire logic power_save_instruction_stop,
    input wire logic irq_pending,
    input wire logic cfg_locked,
    input wire logic wdt_enabled,
    input wire logic wdt_timeout,
    input wire logic clock_failure_monitor_enabled,
    input wire logic [2:0] cur_osc,
    // Outputs
    input wire logic [15:0] rdata,
    input wire pmc_pkg::pmc_ctrl_s ctrl,
    input wire logic core_tick,
    input wire logic [2:0] resume_osc,
    input wire logic [2:0] new_osc_select,
    input wire logic [NPERIPH-1:0] periph_en,
    input wire logic exec_restart
);
    import pmc_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // core_tick high only in run, so it qualifies the instruction
    sequence halt_s;
        ctrl.sys_clk_en && !ctrl.core_clk_en;
    endsequence
    sequence restart_s;
        ctrl.core_clk_en ##2 exec_restart;
    endsequence
    ////////////////////////////////////////////////////////////////
    stop_entry_a: assert property (core_tick && power_save_instruction_exec && power_save_instruction_stop |=>
        !ctrl.sys_clk_en && !ctrl.osc_en && ctrl.low_power_rc_osc_en == $past(wdt_enabled) && resume_osc == $past(cur_osc))
        else $error("deep stop entry wrong");
    halt_entry_a: assert property (core_tick && power_save_instruction_exec && !power_save_instruction_stop |=>
        halt_s ##0 ctrl.periph_clk_en && ctrl.low_power_rc_osc_en == $past(wdt_enabled || clock_failure_monitor_enabled))
        else $error("core-halt entry wrong");
    wdt_clear_a: assert property (ctrl.wdt_clear == $past(core_tick && power_save_instruction_exec && wdt_enabled))
        else $error("watchdog clear wrong");
    stop_quiet_a: assert property (!ctrl.sys_clk_en && !$past(rst) |->
        !ctrl.clock_failure_monitor_active && periph_en == '0 && !core_tick)
        else $error("activity in deep stop");
    halt_wake_a: assert property (halt_s ##0 (irq_pending || wdt_timeout) |=> restart_s)
        else $error("core-halt wake timing");
    stop_wake_a: assert property (!ctrl.sys_clk_en && !$past(rst) && (irq_pending || wdt_timeout) |=>
        ##2 exec_restart)
        else $error("deep stop wake timing");
    rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
        else $error("read data outside slot");
    osc_write_a: assert property (bus.wr && bus.addr == `PMC_ADDR_OSC_CTRL |=>
        new_osc_select == ($past(cfg_locked) ? $past(new_osc_select) : $past(bus.wdata[10:8])))
        else $error("oscillator request wrong");
endmodule // pmc_chk

// [verification/power_mode_clock_gating_controller_tb.sv]
// Testbench for the power-mode controller
`timescale 1ns/10ps
module power_mode_clock_gating_controller_tb;
    import pmc_pkg::*;
    logic clock, rst, power_save_instruction_exec, power_save_instruction_stop, irq_pending, cfg_locked;
    logic wdt_enabled, wdt_timeout, clock_failure_monitor_enabled, core_tick, exec_restart, rd_seen;
    logic [2:0] cur_osc, resume_osc, new_osc_select;
    logic [7:0] periph_en, restarts, n;
    logic [15:0] rdata, ticks, t, r;
    logic [15:0] exp_q[$];
    pmc_bus_s bus;
    pmc_ctrl_s ctrl;
    integer failures = 0, comparisons = 0, cycles = 0, seed = 4396;
    pmc_top #(.NPERIPH(8)) DUT (.clock, .rst, .bus, .rdata, .power_save_instruction_exec, .power_save_instruction_stop, .irq_pending,
        .cfg_locked, .wdt_enabled, .wdt_timeout, .clock_failure_monitor_enabled, .cur_osc, .ctrl, .core_tick, .resume_osc,
        .new_osc_select, .periph_en, .exec_restart);
    pmc_core_mdl core_i (.clock, .rst, .core_tick, .exec_restart, .ticks, .restarts);
    ////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("Comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] e, input string msg);
        comparisons++;
        if (got !== e) begin
            failures++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    // On reads d is the expected word
    task automatic put(input logic [3:0] a, input logic [15:0] d, input logic rd);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: !rd, rd: rd};
        if (rd)
            exp_q.push_back(d);
        @(posedge clock);
        bus <= '0;
    endtask
    task automatic pwr(input logic stop, input logic irq);
        @(posedge clock);
        power_save_instruction_exec <= 1'b1;
        power_save_instruction_stop <= stop;
        irq_pending <= irq;
        @(posedge clock);
        power_save_instruction_exec <= 1'b0;
        irq_pending <= 1'b0;
        #1;
    endtask
    task automatic wake(input logic by_irq);
        n = restarts;
        @(posedge clock);
        irq_pending <= by_irq;
        wdt_timeout <= !by_irq;
        repeat (10) @(posedge clock);
        irq_pending <= 1'b0;
        wdt_timeout <= 1'b0;
        chk(restarts, n + 8'h01, "no restart");
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clock) rd_seen <= bus.rd;
    always @(negedge clock) if (rd_seen === 1'b1) chk(rdata, exp_q.pop_front(), "read data");
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        rst = 1'b1;
        bus = '0;
        {power_save_instruction_exec, power_save_instruction_stop, irq_pending, cfg_locked, wdt_enabled, wdt_timeout, clock_failure_monitor_enabled} = 7'h00;
        cur_osc = 3'h1;
        r = $random(seed);
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        put(4'h1, 16'h0000, 1);
        chk({periph_en, 7'h00, core_tick}, 16'hff01, "run after reset");
        put(4'h3, {8'h00, r[15:8]}, 0);
        repeat (2) @(posedge clock);
        #1;
        chk({8'h00, periph_en}, {8'h00, ~r[15:8]}, "peripheral disable");
        put(4'h0, {5'h00, r[10:8], 8'h00}, 0);
        cfg_locked <= 1'b1;
        put(4'h0, {5'h00, ~r[10:8], 8'h00}, 0);
        put(4'h0, {5'h00, r[10:8], 8'h00}, 1);
        chk(new_osc_select, r[10:8], "oscillator request");
        cfg_locked <= 1'b0;
        put(4'hf, 16'h0000, 1);
        for (int i = 0; i < 4; i++) begin
            wdt_enabled <= i[0];
            clock_failure_monitor_enabled <= i[1];
            pwr(0, 0);
            chk({ctrl.core_clk_en, ctrl.sys_clk_en, ctrl.periph_clk_en, ctrl.wdt_clear, ctrl.low_power_rc_osc_en},
                {3'b011, i[0], i != 0}, "core-halt");
            wake(i[1]);
        end
        @(posedge clock);
        cur_osc <= r[5:3];
        wdt_enabled <= r[6];
        pwr(1, 0);
        chk({ctrl.sys_clk_en, ctrl.osc_en, ctrl.clock_failure_monitor_active, ctrl.low_power_rc_osc_en}, {3'b000, r[6]}, "stop");
        chk({periph_en, core_tick}, 9'h000, "stop quiet");
        @(posedge clock);
        cur_osc <= ~r[5:3];
        wake(r[7]);
        chk(resume_osc, r[5:3], "resume source");
        put(4'h2, {10'h000, r[5:3], 3'h0}, 1);
        n = restarts;
        pwr(0, 1);
        repeat (8) @(posedge clock);
        chk(restarts, n + 8'h01, "held interrupt");
        for (int i = 0; i < 8; i++) begin
            put(4'h1, {1'b0, i[2:0], 12'h800}, 0);
            repeat (128) @(posedge clock);
            t = ticks;
            repeat (256) @(posedge clock);
            chk(ticks - t, 16'h0100 >> i, "slowdown ratio");
            chk(ctrl.periph_clk_en, 1'b1, "peripheral clock");
        end
        for (int j = 0; j < 2; j++) begin
            put(4'h1, {j[0], 15'h2800}, 0);
            @(posedge clock);
            irq_pending <= 1'b1;
            @(posedge clock);
            irq_pending <= 1'b0;
            put(4'h1, {j[0], 3'h2, !j[0], 11'h000}, 1);
        end
        repeat (3) @(posedge clock);
        stop_test();
    end
endmodule // power_mode_clock_gating_controller_tb
bind pmc_top pmc_chk #(.NPERIPH(NPERIPH)) chk_i (.clock, .rst, .bus, .power_save_instruction_exec, .power_save_instruction_stop,
    .irq_pending, .cfg_locked, .wdt_enabled, .wdt_timeout, .clock_failure_monitor_enabled, .cur_osc, .rdata, .ctrl,
    .core_tick, .resume_osc, .new_osc_select, .periph_en, .exec_restart);
